// ===== hw/bridge_cmd_status_pkg.sv
// Package for the primary command/status register pair of a PCI-to-PCI bridge.
// Assumes the bridge's configuration target has already decoded type-1 cycles.
package bridge_cmd_status_pkg;

  // ----------------------------------------------------------------
  // Register placement
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_STATUS_OFFSET = 8'h04;
  localparam logic [7:0]  HEADER_BYTES      = 8'h40;

  // ----------------------------------------------------------------
  // Command bit positions
  // ----------------------------------------------------------------
  localparam int CMD_IO_EN      = 0;
  localparam int CMD_MEM_EN     = 1;
  localparam int CMD_MASTER_EN  = 2;
  localparam int CMD_SPECIAL    = 3;
  localparam int CMD_MWI        = 4;
  localparam int CMD_SNOOP_EN   = 5;
  localparam int CMD_PARITY_EN  = 6;
  localparam int CMD_STEPPING   = 7;
  localparam int CMD_SERR_EN    = 8;
  localparam int CMD_FAST_B2B   = 9;

  localparam logic [15:0] CMD_RESET      = 16'h0000;
  localparam logic [15:0] CMD_WRITE_MASK = 16'h0367;

  // ----------------------------------------------------------------
  // Status fields (bit numbers within the 32-bit dword)
  // ----------------------------------------------------------------
  localparam int STS_CAP_LIST      = 20;
  localparam int STS_66MHZ         = 21;
  localparam int STS_FAST_B2B      = 23;
  localparam int STS_DATA_PERR     = 24;
  localparam int STS_DEVSEL_LO     = 25;
  localparam int STS_SIG_TABORT    = 27;
  localparam int STS_RCV_TABORT    = 28;
  localparam int STS_RCV_MABORT    = 29;
  localparam int STS_SIG_SERR      = 30;
  localparam int STS_DET_PERR      = 31;

  localparam logic [1:0]  DEVSEL_MEDIUM  = 2'b01;
  // Read-only values for dword bits 26:16, status bits 10:0 except flag bit 24
  localparam logic [10:0] STS_FIXED      = 11'h2b0;

  // Sticky flags, index order: 24, 27, 28, 29, 30, 31
  localparam int          FLAG_COUNT     = 6;
  localparam int          FLAG_DATA_PERR = 0;
  localparam int          FLAG_SIG_TAB   = 1;
  localparam int          FLAG_RCV_TAB   = 2;
  localparam int          FLAG_RCV_MAB   = 3;
  localparam int          FLAG_SIG_SERR  = 4;
  localparam int          FLAG_DET_PERR  = 5;

  // ----------------------------------------------------------------
  // VGA palette addresses, low ten bits of the I/O address
  // ----------------------------------------------------------------
  localparam logic [9:0]  PALETTE_MASK_A = 10'h3c6;
  localparam logic [9:0]  PALETTE_WR_A   = 10'h3c8;
  localparam logic [9:0]  PALETTE_DATA_A = 10'h3c9;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  offset;
    logic [3:0]  be;
    logic [31:0] data;
  } cfg_req_t;

  typedef struct packed {
    logic io_decode_en;
    logic mem_decode_en;
    logic primary_master_en;
    logic secondary_claim_en;
    logic parity_response_en;
    logic stepping_en;
    logic fast_b2b_en;
  } cmd_ctrl_t;

  typedef struct packed {
    logic signaled_target_abort;
    logic received_target_abort;
    logic received_master_abort;
    logic parity_error_detected;
    logic system_error_request;
  } bus_event_t;

endpackage : bridge_cmd_status_pkg

// ===== hw/sticky_flag.sv
// One software-clearable status flag.
// Assumes set and clear are single-cycle pulses in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module sticky_flag (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Control
  input  wire logic set_in,
  input  wire logic clear_in,
  // State
  output logic      flag_out
);

  // Set wins so an event in the clearing cycle is never lost
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_out <= 1'b0;
    end else if (set_in) begin
      flag_out <= 1'b1;
    end else if (clear_in) begin
      flag_out <= 1'b0;
    end
  end

endmodule : sticky_flag
`default_nettype wire

// ===== hw/bridge_primary_cmd_status.sv
// Primary command and status registers of a two-port PCI-to-PCI bridge.
// Assumes configuration cycles arrive already decoded as single-cycle requests.
// Operation
// - Command bit 0 enables I/O decoding on primary; resets zero.
// - Command bit 1 enables memory decoding on primary; resets zero.
// - Command bit 2 gates primary mastering and secondary memory/I/O claiming.
// - Command bit 3 special-cycle enable is read-only zero.
// - Command bit 4 write-and-invalidate enable is read-only zero.
// - Bit 5 claims primary I/O writes to 3C6h, 3C8h, 3C9h, low ten bits.
// - Bit 6 makes parity errors take normal action; resets zero.
// - Bit 7 stepping control is read-only zero; stepping stays off.
// - Bit 8 gates the primary system-error driver; resets zero.
// - Bit 9 permits fast back-to-back mastering to different targets.
// - Command bits 15:10 read zero.
// - Status bit 20 reads one, capability list; bits 19:16 and 22 zero.
// - Status bit 21 reads one, 66MHz capable.
// - Status bit 23 reads one, fast back-to-back target capable.
// - Status bit 24 sets on parity-error pin while bit 6 set.
// - Status bits 26:25 read 01, medium device-select timing.
// - Status bit 27 sets when the bridge signals target abort.
// - Status bit 28 sets when its master cycle gets target abort.
// - Status bit 29 sets when its master cycle gets master abort.
// - Status bit 30 sets whenever the system-error pin is driven.
// - Status bit 31 sets on any primary parity error detected.
// - Reached by configuration cycles at dword 04h of the 64-byte header.
`timescale 1ns/1ps
`default_nettype none
module bridge_primary_cmd_status (
  // Clock and reset
  input  wire logic                             ref_clk_in,
  input  wire logic                             rst_n_in,
  // Configuration access
  input  wire bridge_cmd_status_pkg::cfg_req_t  cfg_req_in,
  output logic                                  cfg_ack_out,
  output logic [31:0]                           cfg_rd_data_out,
  // Primary bus events and decode
  input  wire bridge_cmd_status_pkg::bus_event_t bus_event_in,
  input  wire logic                             primary_parity_error_n_in,
  input  wire logic                             io_write_in,
  input  wire logic [15:0]                      io_addr_in,
  output logic                                  palette_claim_out,
  // Control to the datapath
  output var bridge_cmd_status_pkg::cmd_ctrl_t  cmd_ctrl_out,
  // Primary system-error pin, open drain
  output logic                                  primary_system_error_n_out,
  output logic                                  primary_system_error_oe_n_out
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  wire logic        hit;
  wire logic        wr_hit;
  wire logic [15:0] cmd_wr_mask;
  wire logic [15:0] cmd_next;
  wire logic [31:0] dword_read;
  wire logic [31:0] rd_data_next;

  assign hit    = (cfg_req_in.offset == bridge_cmd_status_pkg::CMD_STATUS_OFFSET);
  assign wr_hit = cfg_req_in.wr && hit;
  assign cmd_wr_mask = {{8{cfg_req_in.be[1]}}, {8{cfg_req_in.be[0]}}}
                       & bridge_cmd_status_pkg::CMD_WRITE_MASK;

  // ----------------------------------------------------------------
  // Command register
  // ----------------------------------------------------------------
  logic [15:0] cmd_reg;

  // Read-only bits are masked off, so 3, 4, 7 and 15:10 stay zero
  assign cmd_next = (cmd_reg & ~cmd_wr_mask) | (cfg_req_in.data[15:0] & cmd_wr_mask);

  always_ff @(posedge ref_clk_in or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      cmd_reg <= bridge_cmd_status_pkg::CMD_RESET;
    end else if (wr_hit) begin
      cmd_reg <= cmd_next;
    end
  end

  assign cmd_ctrl_out.io_decode_en       = cmd_reg[bridge_cmd_status_pkg::CMD_IO_EN];
  assign cmd_ctrl_out.mem_decode_en      = cmd_reg[bridge_cmd_status_pkg::CMD_MEM_EN];
  assign cmd_ctrl_out.primary_master_en  = cmd_reg[bridge_cmd_status_pkg::CMD_MASTER_EN];
  assign cmd_ctrl_out.secondary_claim_en = cmd_reg[bridge_cmd_status_pkg::CMD_MASTER_EN];
  assign cmd_ctrl_out.parity_response_en = cmd_reg[bridge_cmd_status_pkg::CMD_PARITY_EN];
  assign cmd_ctrl_out.stepping_en        = cmd_reg[bridge_cmd_status_pkg::CMD_STEPPING];
  assign cmd_ctrl_out.fast_b2b_en        = cmd_reg[bridge_cmd_status_pkg::CMD_FAST_B2B];

  // ----------------------------------------------------------------
  // Palette snoop decode
  // ----------------------------------------------------------------
  // Upper address bits 15:10 are aliases and deliberately not compared
  wire logic palette_addr;

  assign palette_addr = (io_addr_in[9:0] == bridge_cmd_status_pkg::PALETTE_MASK_A)
                     || (io_addr_in[9:0] == bridge_cmd_status_pkg::PALETTE_WR_A)
                     || (io_addr_in[9:0] == bridge_cmd_status_pkg::PALETTE_DATA_A);
  assign palette_claim_out = cmd_reg[bridge_cmd_status_pkg::CMD_SNOOP_EN]
                             && io_write_in && palette_addr;

  // ----------------------------------------------------------------
  // System-error driver
  // ----------------------------------------------------------------
  wire logic serr_drive;

  assign serr_drive = bus_event_in.system_error_request
                      && cmd_reg[bridge_cmd_status_pkg::CMD_SERR_EN];
  assign primary_system_error_n_out    = 1'b0;
  assign primary_system_error_oe_n_out = !serr_drive;

  // ----------------------------------------------------------------
  // Sticky status flags
  // ----------------------------------------------------------------
  wire logic [bridge_cmd_status_pkg::FLAG_COUNT-1:0] flag_set;
  wire logic [bridge_cmd_status_pkg::FLAG_COUNT-1:0] flag_clear;
  wire logic [bridge_cmd_status_pkg::FLAG_COUNT-1:0] flag_q;

  // Parity-pin reporting only counts while parity response is on
  assign flag_set[bridge_cmd_status_pkg::FLAG_DATA_PERR] = !primary_parity_error_n_in
      && cmd_reg[bridge_cmd_status_pkg::CMD_PARITY_EN];
  assign flag_set[bridge_cmd_status_pkg::FLAG_SIG_TAB] =
      bus_event_in.signaled_target_abort;
  assign flag_set[bridge_cmd_status_pkg::FLAG_RCV_TAB] =
      bus_event_in.received_target_abort;
  assign flag_set[bridge_cmd_status_pkg::FLAG_RCV_MAB] =
      bus_event_in.received_master_abort;
  assign flag_set[bridge_cmd_status_pkg::FLAG_SIG_SERR] = serr_drive;
  assign flag_set[bridge_cmd_status_pkg::FLAG_DET_PERR] =
      bus_event_in.parity_error_detected;

  // All six flags sit in byte lane 3, bits 24 and 27..31
  assign flag_clear = {6{wr_hit && cfg_req_in.be[3]}}
                      & {cfg_req_in.data[31:27], cfg_req_in.data[24]};

  genvar g;
  generate
    for (g = 0; g < bridge_cmd_status_pkg::FLAG_COUNT; g++) begin : g_flag
      sticky_flag u_flag (
        .clk_in   (ref_clk_in),
        .rst_n_in (rst_sync_reg),
        .set_in   (flag_set[g]),
        .clear_in (flag_clear[g]),
        .flag_out (flag_q[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  assign dword_read = {flag_q[5:1],
                       bridge_cmd_status_pkg::STS_FIXED[10:9],
                       flag_q[0],
                       bridge_cmd_status_pkg::STS_FIXED[7:0],
                       cmd_reg};
  // Other header dwords belong elsewhere and read as zero here
  assign rd_data_next = (cfg_req_in.rd && hit) ? dword_read : 32'h0000_0000;

  always_ff @(posedge ref_clk_in or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      cfg_ack_out     <= 1'b0;
      cfg_rd_data_out <= 32'h0000_0000;
    end else begin
      cfg_ack_out     <= cfg_req_in.rd || cfg_req_in.wr;
      cfg_rd_data_out <= rd_data_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_cmd_write_lane0;
    wr_hit && cfg_req_in.be[0];
  endsequence

  property p_io_write;
    @(posedge ref_clk_in) disable iff (!rst_sync_reg)
    s_cmd_write_lane0 |=> cmd_ctrl_out.io_decode_en == $past(cfg_req_in.data[0]);
  endproperty
  a_io_write: assert property (p_io_write) else $error("io decode enable not written");

  property p_mem_write;
    @(posedge ref_clk_in) disable iff (!rst_sync_reg)
    s_cmd_write_lane0 |=> cmd_ctrl_out.mem_decode_en == $past(cfg_req_in.data[1]);
  endproperty
  a_mem_write: assert property (p_mem_write) else $error("mem decode enable not written");

  property p_master_pair;
    @(posedge ref_clk_in) disable iff (!rst_sync_reg)
    s_cmd_write_lane0 |=> cmd_ctrl_out.primary_master_en == $past(cfg_req_in.data[2])
                          && cmd_ctrl_out.secondary_claim_en == $past(cfg_req_in.data[2]);
  endproperty
  a_master_pair: assert property (p_master_pair) else $error("master enable mismatch");

  property p_ro_cmd_bits;
    @(posedge ref_clk_in) disable iff (!rst_sync_reg)
    cfg_req_in.rd && hit |=> cfg_rd_data_out[15:10] == 6'h00 && cfg_rd_data_out[4:3] == 2'b00
                             && !cfg_rd_data_out[7] && !cmd_ctrl_out.stepping_en;
  endproperty
  a_ro_cmd_bits: assert property (p_ro_cmd_bits) else $error("read-only command bit set");

  property p_palette;
    @(posedge ref_clk_in) disable iff (!rst_sync_reg)
    io_write_in && io_addr_in[9:0] == 10'h3c8 && cmd_reg[5] |-> palette_claim_out;
  endproperty
  a_palette: assert property (p_palette) else $error("palette write not claimed");

  property p_serr_gate;
    @(posedge ref_clk_in) disable iff (!rst_sync_reg)
    !primary_system_error_oe_n_out |-> cmd_reg[8] && bus_event_in.system_error_request;
  endproperty
  a_serr_gate: assert property (p_serr_gate) else $error("error pin driven while disabled");

  property p_serr_flag;
    @(posedge ref_clk_in) disable iff (!rst_sync_reg)
    !primary_system_error_oe_n_out |=> flag_q[4];
  endproperty
  a_serr_flag: assert property (p_serr_flag) else $error("system error flag not set");

  property p_parity_flag;
    @(posedge ref_clk_in) disable iff (!rst_sync_reg)
    !primary_parity_error_n_in && !cmd_reg[6] && !flag_q[0] && !wr_hit |=> !flag_q[0];
  endproperty
  a_parity_flag: assert property (p_parity_flag) else $error("parity flag set while off");

  sequence s_clear_quiet;
    wr_hit && cfg_req_in.be[3] && cfg_req_in.data[29] && !bus_event_in.received_master_abort;
  endsequence

  property p_w1c;
    @(posedge ref_clk_in) disable iff (!rst_sync_reg)
    s_clear_quiet |=> !flag_q[3];
  endproperty
  a_w1c: assert property (p_w1c) else $error("master abort flag not cleared");

  property p_fixed_status;
    @(posedge ref_clk_in) disable iff (!rst_sync_reg)
    cfg_req_in.rd && hit |=> cfg_rd_data_out[26:25] == 2'b01 && cfg_rd_data_out[23:20] == 4'hb
                             && cfg_rd_data_out[19:16] == 4'h0;
  endproperty
  a_fixed_status: assert property (p_fixed_status) else $error("fixed status bits wrong");

  sequence s_cmd_write_lane1;
    wr_hit && cfg_req_in.be[1];
  endsequence

  property p_fast_b2b;
    @(posedge ref_clk_in) disable iff (!rst_sync_reg)
    s_cmd_write_lane1 |=> cmd_ctrl_out.fast_b2b_en == $past(cfg_req_in.data[9]);
  endproperty
  a_fast_b2b: assert property (p_fast_b2b) else $error("fast b2b enable not written");

  property p_parity_resp;
    @(posedge ref_clk_in) disable iff (!rst_sync_reg)
    s_cmd_write_lane0 |=> cmd_ctrl_out.parity_response_en == $past(cfg_req_in.data[6]);
  endproperty
  a_parity_resp: assert property (p_parity_resp) else $error("parity enable not written");

  property p_parity_set;
    @(posedge ref_clk_in) disable iff (!rst_sync_reg)
    !primary_parity_error_n_in && cmd_reg[6] |=> flag_q[0];
  endproperty
  a_parity_set: assert property (p_parity_set) else $error("data parity flag not set");

  property p_sig_tab;
    @(posedge ref_clk_in) disable iff (!rst_sync_reg)
    bus_event_in.signaled_target_abort |=> flag_q[1];
  endproperty
  a_sig_tab: assert property (p_sig_tab) else $error("signaled abort flag not set");

  property p_rcv_tab;
    @(posedge ref_clk_in) disable iff (!rst_sync_reg)
    bus_event_in.received_target_abort |=> flag_q[2];
  endproperty
  a_rcv_tab: assert property (p_rcv_tab) else $error("target abort flag not set");

  property p_rcv_mab;
    @(posedge ref_clk_in) disable iff (!rst_sync_reg)
    bus_event_in.received_master_abort |=> flag_q[3];
  endproperty
  a_rcv_mab: assert property (p_rcv_mab) else $error("master abort flag not set");

  property p_det_perr;
    @(posedge ref_clk_in) disable iff (!rst_sync_reg)
    bus_event_in.parity_error_detected |=> flag_q[5];
  endproperty
  a_det_perr: assert property (p_det_perr) else $error("detected parity flag not set");

  property p_keep_on_zero;
    @(posedge ref_clk_in) disable iff (!rst_sync_reg)
    wr_hit && cfg_req_in.be[3] && !cfg_req_in.data[29] && flag_q[3] |=> flag_q[3];
  endproperty
  a_keep_on_zero: assert property (p_keep_on_zero) else $error("flag cleared by zero");

  property p_ack;
    @(posedge ref_clk_in) disable iff (!rst_sync_reg)
    cfg_req_in.rd || cfg_req_in.wr |=> cfg_ack_out;
  endproperty
  a_ack: assert property (p_ack) else $error("config access not acknowledged");

endmodule : bridge_primary_cmd_status
`default_nettype wire

// ===== test/config_host_model.sv
// Configuration-software model: issues decoded config reads and writes.
// Assumes the block answers with a one-cycle ack one edge after each request.
`timescale 1ns/1ps
`default_nettype none
module config_host_model (
  // Clock
  input  wire logic                            clk_in,
  // Answer from the register pair
  input  wire logic                            ack_in,
  input  wire logic [31:0]                     rd_data_in,
  // Request toward the register pair
  output var  bridge_cmd_status_pkg::cfg_req_t req_out
);
  initial req_out = '0;

  // ----------------------------------------------------------------
  // One access: a single-cycle request, answer sampled one edge later
  // ----------------------------------------------------------------
  task automatic access(input  logic        wr,
                        input  logic [7:0]  offset,
                        input  logic [3:0]  be,
                        input  logic [31:0] data,
                        output logic [31:0] rd_data,
                        output logic        acked);
    @(posedge clk_in);
    #1;
    req_out.rd     = !wr;
    req_out.wr     = wr;
    req_out.offset = offset;
    req_out.be     = be;
    req_out.data   = data;
    @(posedge clk_in);
    #1;
    // Released strobes drop; be and data invert so they show no stale value, offset is kept
    req_out.rd   = 1'b0;
    req_out.wr   = 1'b0;
    req_out.be   = ~be;
    req_out.data = ~data;
    rd_data      = rd_data_in;
    acked        = ack_in;
  endtask : access
endmodule : config_host_model
`default_nettype wire

// ===== test/bridge_primary_cmd_status_test.sv
// Self-checking bench for the primary command/status register pair.
// Assumes the host model drives all config traffic; events come from here.
`timescale 1ns/1ps
`default_nettype none
module bridge_primary_cmd_status_test;
  localparam logic [31:0] FIXED = 32'h02b0_0000;
  logic                              ref_clk_in = 1'b0;
  logic                              rst_n_in   = 1'b0;
  bridge_cmd_status_pkg::cfg_req_t   cfg_req;
  logic                              cfg_ack;
  logic [31:0]                       cfg_rd_data;
  bridge_cmd_status_pkg::bus_event_t bus_event  = '0;
  logic                              parity_n   = 1'b1;
  logic                              io_write   = 1'b0;
  logic [15:0]                       io_addr    = 16'h0000;
  logic                              palette_claim;
  bridge_cmd_status_pkg::cmd_ctrl_t  cmd_ctrl;
  logic                              serr_n;
  logic                              serr_oe_n;
  logic [9:0]                        pal;
  logic [15:0]                       exp_cmd    = 16'h0000;
  logic [31:0]                       exp_flags  = 32'h0000_0000;
  int                                fail_count = 0;
  int                                tests_run  = 0;

  always #10 ref_clk_in = ~ref_clk_in;

  bridge_primary_cmd_status dut (
    .ref_clk_in                    (ref_clk_in),
    .rst_n_in                      (rst_n_in),
    .cfg_req_in                    (cfg_req),
    .cfg_ack_out                   (cfg_ack),
    .cfg_rd_data_out               (cfg_rd_data),
    .bus_event_in                  (bus_event),
    .primary_parity_error_n_in     (parity_n),
    .io_write_in                   (io_write),
    .io_addr_in                    (io_addr),
    .palette_claim_out             (palette_claim),
    .cmd_ctrl_out                  (cmd_ctrl),
    .primary_system_error_n_out    (serr_n),
    .primary_system_error_oe_n_out (serr_oe_n)
  );

  config_host_model host (
    .clk_in     (ref_clk_in),
    .ack_in     (cfg_ack),
    .rd_data_in (cfg_rd_data),
    .req_out    (cfg_req)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic reg_read(input logic [7:0] offset, input logic [31:0] exp);
    logic [31:0] d;
    logic        a;
    host.access(1'b0, offset, 4'hf, 32'h0000_0000, d, a);
    check({31'h0, a}, 32'h0000_0001);
    check(d, exp);
  endtask : reg_read

  task automatic reg_write(input logic [7:0] offset, input logic [3:0] be,
                           input logic [31:0] data);
    logic [31:0] d;
    logic        a;
    host.access(1'b1, offset, be, data, d, a);
    check({31'h0, a}, 32'h0000_0001);
    check(d, 32'h0000_0000);
  endtask : reg_write

  // Expected dword from the tracked command and flag state
  function automatic logic [31:0] status_word();
    return FIXED | exp_flags | {16'h0000, exp_cmd};
  endfunction : status_word

  task automatic pulse_event(input bridge_cmd_status_pkg::bus_event_t ev);
    @(posedge ref_clk_in);
    #1 bus_event = ev;
    @(posedge ref_clk_in);
    #1 bus_event = '0;
  endtask : pulse_event

  task automatic pulse_parity_pin();
    @(posedge ref_clk_in);
    #1 parity_n = 1'b0;
    @(posedge ref_clk_in);
    #1 parity_n = 1'b1;
  endtask : pulse_parity_pin

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Watchdog: the sequence needs a few hundred cycles at most
  // ----------------------------------------------------------------
  initial begin
    #50000;
    fail_count++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk_in);
    #1 rst_n_in = 1'b1;
    repeat (3) @(posedge ref_clk_in);
    reg_read(8'h04, FIXED);
    check(32'(cmd_ctrl), 32'h0000_0000);
    reg_write(8'h04, 4'h3, 32'h0000_ffff);
    exp_cmd = 16'h0367;
    reg_read(8'h04, status_word());
    check(32'(cmd_ctrl), 32'h0000_007d);
    // Palette hits with alias bits 0, 13 and 26, then a near miss and a non-write
    for (int i = 0; i < 5; i++) begin
      case (i)
        0: pal = 10'h3c6;
        1: pal = 10'h3c8;
        2: pal = 10'h3c9;
        3: pal = 10'h3c7;
        default: pal = 10'h3c8;
      endcase
      @(posedge ref_clk_in);
      #1 io_write = (i != 4);
      io_addr = {6'(i * 13), pal};
      #1 check({31'h0, palette_claim}, {31'h0, i < 3});
    end
    reg_write(8'h04, 4'h1, 32'h0000_0047);
    exp_cmd = 16'h0347;
    io_write = 1'b1;
    io_addr  = 16'hfc00 | 16'h03c6;
    #1 check({31'h0, palette_claim}, 32'h0000_0000);
    @(posedge ref_clk_in);
    #1 io_write = 1'b0;
    for (int i = 1; i < 5; i++) begin
      pulse_event(bridge_cmd_status_pkg::bus_event_t'(5'(1 << i)));
      exp_flags = exp_flags | (32'h1 << ((i == 1) ? 31 : 31 - i));
      reg_read(8'h04, status_word());
    end
    pulse_parity_pin();
    exp_flags = exp_flags | 32'h0100_0000;
    reg_read(8'h04, status_word());
    reg_write(8'h04, 4'h8, 32'h0000_0000);
    reg_read(8'h04, status_word());
    reg_write(8'h04, 4'h8, 32'hf900_0000);
    exp_flags = 32'h0000_0000;
    reg_read(8'h04, status_word());
    reg_write(8'h04, 4'h1, 32'h0000_0007);
    exp_cmd = 16'h0307;
    pulse_parity_pin();
    reg_read(8'h04, status_word());
    // System-error driver gated by command bit 8
    @(posedge ref_clk_in);
    #1 bus_event.system_error_request = 1'b1;
    #1 check({30'h0, serr_oe_n, serr_n}, 32'h0000_0000);
    @(posedge ref_clk_in);
    #1 bus_event.system_error_request = 1'b0;
    exp_flags = 32'h4000_0000;
    reg_read(8'h04, status_word());
    // Clear flag 30 first so a drive while disabled would show
    reg_write(8'h04, 4'h8, 32'h4000_0000);
    exp_flags = 32'h0000_0000;
    reg_write(8'h04, 4'h2, 32'h0000_0000);
    exp_cmd = 16'h0007;
    @(posedge ref_clk_in);
    #1 bus_event.system_error_request = 1'b1;
    #1 check({31'h0, serr_oe_n}, 32'h0000_0001);
    @(posedge ref_clk_in);
    #1 bus_event.system_error_request = 1'b0;
    reg_read(8'h04, status_word());
    reg_write(8'h08, 4'hf, 32'hffff_ffff);
    reg_read(8'h08, 32'h0000_0000);
    reg_read(8'h04, status_word());
    // Mid-run reset with a flag and command bits set
    pulse_event(bridge_cmd_status_pkg::bus_event_t'(5'h10));
    rst_n_in = 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1 rst_n_in = 1'b1;
    repeat (3) @(posedge ref_clk_in);
    reg_read(8'h04, FIXED);
    check(32'(cmd_ctrl), 32'h0000_0000);
    print_verdict();
  end
endmodule : bridge_primary_cmd_status_test
`default_nettype wire
